// *** core/elr_event_router.sv ***
// What this block does
// - Eight-bit source selector held per destination
// - Forward up to 46 events without processor
// - Codes 08h-0Fh: timer channels 1, 2
// - Codes 10h-1Ah: timer channels 3, 4
// - Codes 1Fh, 22h-24h, 28h-2Ah: other timers
// - Codes 34h, 35h, 58h: converter events
// - Codes 3Ah-3Dh: serial channel five events
// - Codes 4Eh-51h: two-wire channel zero events
// - Codes 59h-5Bh: comparators and voltage detector
// - Codes 61h, 69h, 6Ah: transfer, software, data-op
// - Codes 63h, 65h, 66h: port edge events
// - Software picks timer action on delivered event
// - Port B single pin edge linkage
// - Port B masked pin group linkage
// - Module stop halts event routing; selector writes still taken
`timescale 1ns/1ns
module elr_event_router
    import elr_pkg::*;
(
    input  wire logic                        ref_clk_in,
    input  wire logic                        reset_in,
    input  wire logic                        stop_in,
    input  wire logic [NUM_DEST-1:0]         sel_wr_in,
    input  wire logic [7:0]                  sel_data_in,
    input  wire logic [NUM_SRC-1:0]          periph_event_in,
    input  wire logic                        sw_event_in,
    input  wire logic [NUM_TIMER-1:0][1:0]   timer_op_in,
    input  wire logic [PORTB_W-1:0]          portb_pins_in,
    input  wire logic                        portb_mode_in,
    input  wire logic [2:0]                  portb_bit_sel_in,
    input  wire logic [PORTB_W-1:0]          portb_group_mask_in,
    output logic      [NUM_DEST-1:0]         dest_event_out,
    output elr_tcmd_s [NUM_TIMER-1:0]        timer_cmd_out,
    output logic                             stopped_out
);

    logic       [7:0]                 link_setting_reg [NUM_DEST];
    elr_top_e   [NUM_TIMER-1:0]       timer_op_reg;
    logic       [NUM_DEST-1:0]        dest_event_reg;
    elr_tcmd_s  [NUM_TIMER-1:0]       timer_cmd_reg;
    logic                             stopped_reg;
    logic       [NUM_SRC-1:0]         src_vec;
    elr_route_s [NUM_DEST-1:0]        route;
    wire        [NUM_DEST-1:0]        dest_hit;
    elr_tcmd_s  [NUM_TIMER-1:0]       timer_cmd_next;
    wire                              pb_single_edge;
    wire                              pb_group_edge;

    ////////////////////////////////////////////////////////////////////////
    // Timer action for one delivered event
    function automatic elr_tcmd_s op_to_cmd(input elr_top_e op);
        elr_tcmd_s c;
        c = '0;
        case (op)
            ELR_TOP_START: c.start = 1'b1;
            ELR_TOP_STOP:  c.stop  = 1'b1;
            ELR_TOP_CLEAR: c.clear = 1'b1;
            ELR_TOP_COUNT: c.count = 1'b1;
            default:       c = '0;
        endcase
        return c;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Port B edge sources
    elr_port_edge u_port_edge
    (
        .ref_clk_in     (ref_clk_in),
        .reset_in       (reset_in),
        .stop_in        (stop_in),
        .pins_in        (portb_pins_in),
        .mode_in        (portb_mode_in),
        .bit_sel_in     (portb_bit_sel_in),
        .group_mask_in  (portb_group_mask_in),
        .single_edge_out(pb_single_edge),
        .group_edge_out (pb_group_edge)
    );

    ////////////////////////////////////////////////////////////////////////
    // Source vector, internal sources replace their input slots
    always_comb
    begin
        src_vec               = periph_event_in;
        src_vec[IDX_PGRP1]    = pb_group_edge;
        src_vec[IDX_PSGL0]    = pb_single_edge;
        src_vec[IDX_SW_EVENT] = sw_event_in;
    end

    ////////////////////////////////////////////////////////////////////////
    // Selection per destination
    genvar d;
    generate
        for (d = 0; d < NUM_DEST; d++)
        begin : g_dest
            assign route[d]    = elr_code_decode(link_setting_reg[d]);
            assign dest_hit[d] = route[d].valid & src_vec[route[d].idx]
                               & ~stop_in;
        end
        for (d = 0; d < NUM_TIMER; d++)
        begin : g_timer
            assign timer_cmd_next[d] = dest_hit[d] ? op_to_cmd(timer_op_reg[d]) : '0;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            for (int i = 0; i < NUM_DEST; i++)
                link_setting_reg[i] <= SEL_RESET;
        end
        else
        begin
            for (int i = 0; i < NUM_DEST; i++)
                if (sel_wr_in[i])
                    link_setting_reg[i] <= sel_data_in;
        end
    end

    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            for (int i = 0; i < NUM_TIMER; i++)
                timer_op_reg[i] <= ELR_TOP_START;
            dest_event_reg <= '0;
            timer_cmd_reg  <= '0;
            stopped_reg    <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < NUM_TIMER; i++)
                timer_op_reg[i] <= elr_top_e'(timer_op_in[i]);
            dest_event_reg <= dest_hit;
            timer_cmd_reg  <= timer_cmd_next;
            stopped_reg    <= stop_in;
        end
    end

    assign dest_event_out = dest_event_reg;
    assign timer_cmd_out  = timer_cmd_reg;
    assign stopped_out    = stopped_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);

    sequence s_hit(int d, logic [7:0] code, logic src);
        !stop_in && link_setting_reg[d] == code && src;
    endsequence

    sequence s_timer_hit(elr_top_e op);
        !stop_in && dest_hit[0] && timer_op_reg[0] == op;
    endsequence

    chk_sel_store: assert property (
        sel_wr_in[1] |=> (link_setting_reg[1] == $past(sel_data_in)) [*1]
        ##1 ($past(sel_wr_in[1]) || link_setting_reg[1] == $past(link_setting_reg[1])))
        else $error("selector not stored or not held");

    chk_mtu_map: assert property (
        s_hit(7, 8'h0f, periph_event_in[7]) |=> dest_event_out[7])
        else $error("code 0f not routed");

    chk_ch4_map: assert property (
        s_hit(2, 8'h1a, periph_event_in[18]) |=> dest_event_out[2])
        else $error("code 1a not routed");

    chk_tmr_map: assert property (
        s_hit(7, 8'h28, periph_event_in[23]) |=> dest_event_out[7])
        else $error("code 28 not routed");

    chk_conv_map: assert property (
        s_hit(0, 8'h58, periph_event_in[36]) |=> dest_event_out[0])
        else $error("code 58 not routed");

    chk_serial_map: assert property (
        s_hit(7, 8'h3d, periph_event_in[31]) |=> dest_event_out[7])
        else $error("code 3d not routed");

    chk_twowire_map: assert property (
        s_hit(0, 8'h4e, periph_event_in[32]) |=> dest_event_out[0])
        else $error("code 4e not routed");

    chk_cmp_map: assert property (
        s_hit(7, 8'h5b, periph_event_in[39]) |=> dest_event_out[7])
        else $error("code 5b not routed");

    chk_sw_map: assert property (
        s_hit(4, 8'h69, sw_event_in) |=> dest_event_out[4])
        else $error("software event not routed");

    chk_port_map: assert property (
        s_hit(2, 8'h65, pb_single_edge) or s_hit(2, 8'h63, pb_group_edge)
        |=> dest_event_out[2])
        else $error("port edge event not routed");

    chk_unmapped_quiet: assert property (
        (link_setting_reg[2] == 8'h00) |=> !dest_event_out[2])
        else $error("event on unlinked destination");

    chk_timer_count: assert property (
        s_timer_hit(ELR_TOP_COUNT) |=> timer_cmd_out[0] == 4'h1)
        else $error("count action wrong");

    chk_timer_start: assert property (
        s_timer_hit(ELR_TOP_START) |=> timer_cmd_out[0] == 4'h8)
        else $error("start action wrong");

    chk_stop_quiet: assert property (
        stop_in [*2] |=> (dest_event_out == '0 && timer_cmd_out == '0 && stopped_out))
        else $error("activity while stopped");

endmodule

// *** core/elr_pkg.sv ***
package elr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Sizes
    localparam int NUM_DEST  = 8;
    localparam int NUM_SRC   = 48;
    localparam int NUM_TIMER = 2;
    localparam int PORTB_W   = 8;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] SEL_RESET      = 8'h00;
    localparam logic       PB_PREV_RESET  = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Source selector codes
    localparam logic [7:0] CODE_MTU_FIRST    = 8'h08;
    localparam logic [7:0] CODE_MTU_LAST     = 8'h1a;
    localparam logic [7:0] CODE_CMT1         = 8'h1f;
    localparam logic [7:0] CODE_TMR0_FIRST   = 8'h22;
    localparam logic [7:0] CODE_TMR0_LAST    = 8'h24;
    localparam logic [7:0] CODE_TMR2_FIRST   = 8'h28;
    localparam logic [7:0] CODE_TMR2_LAST    = 8'h2a;
    localparam logic [7:0] CODE_ADC_CMP_MET  = 8'h34;
    localparam logic [7:0] CODE_ADC_CMP_MISS = 8'h35;
    localparam logic [7:0] CODE_SER5_FIRST   = 8'h3a;
    localparam logic [7:0] CODE_SER5_LAST    = 8'h3d;
    localparam logic [7:0] CODE_TWI0_FIRST   = 8'h4e;
    localparam logic [7:0] CODE_TWI0_LAST    = 8'h51;
    localparam logic [7:0] CODE_ADC_END      = 8'h58;
    localparam logic [7:0] CODE_CMP0         = 8'h59;
    localparam logic [7:0] CODE_CMP01        = 8'h5a;
    localparam logic [7:0] CODE_VDET1        = 8'h5b;
    localparam logic [7:0] CODE_XFER_END     = 8'h61;
    localparam logic [7:0] CODE_PGRP1        = 8'h63;
    localparam logic [7:0] CODE_PSGL0        = 8'h65;
    localparam logic [7:0] CODE_PSGL1        = 8'h66;
    localparam logic [7:0] CODE_SW_EVENT     = 8'h69;
    localparam logic [7:0] CODE_DOC          = 8'h6a;

    ////////////////////////////////////////////////////////////////////////
    // Source vector positions
    typedef logic [5:0] elr_idx_t;

    localparam elr_idx_t IDX_MTU_BASE     = 6'h00;
    localparam elr_idx_t IDX_CMT1         = 6'h13;
    localparam elr_idx_t IDX_TMR0_BASE    = 6'h14;
    localparam elr_idx_t IDX_TMR2_BASE    = 6'h17;
    localparam elr_idx_t IDX_ADC_CMP_MET  = 6'h1a;
    localparam elr_idx_t IDX_ADC_CMP_MISS = 6'h1b;
    localparam elr_idx_t IDX_SER5_BASE    = 6'h1c;
    localparam elr_idx_t IDX_TWI0_BASE    = 6'h20;
    localparam elr_idx_t IDX_ADC_END      = 6'h24;
    localparam elr_idx_t IDX_CMP0         = 6'h25;
    localparam elr_idx_t IDX_CMP01        = 6'h26;
    localparam elr_idx_t IDX_VDET1        = 6'h27;
    localparam elr_idx_t IDX_XFER_END     = 6'h28;
    localparam elr_idx_t IDX_PGRP1        = 6'h29;
    localparam elr_idx_t IDX_PSGL0        = 6'h2a;
    localparam elr_idx_t IDX_PSGL1        = 6'h2b;
    localparam elr_idx_t IDX_SW_EVENT     = 6'h2c;
    localparam elr_idx_t IDX_DOC          = 6'h2d;

    ////////////////////////////////////////////////////////////////////////
    // Modes and carriers
    localparam logic PB_MODE_SINGLE = 1'b0;
    localparam logic PB_MODE_GROUP  = 1'b1;

    typedef enum logic [1:0]
    {
        ELR_TOP_START = 2'h0,
        ELR_TOP_STOP  = 2'h1,
        ELR_TOP_CLEAR = 2'h2,
        ELR_TOP_COUNT = 2'h3
    } elr_top_e;

    typedef struct packed
    {
        logic     valid;
        elr_idx_t idx;
    } elr_route_s;

    typedef struct packed
    {
        logic start;
        logic stop;
        logic clear;
        logic count;
    } elr_tcmd_s;

    ////////////////////////////////////////////////////////////////////////
    // Selector code to source position
    function automatic elr_route_s elr_code_decode(input logic [7:0] code);
        elr_route_s r;
        r.valid = 1'b1;
        r.idx   = IDX_MTU_BASE;
        if (code >= CODE_MTU_FIRST && code <= CODE_MTU_LAST)
            r.idx = elr_idx_t'(code - CODE_MTU_FIRST) + IDX_MTU_BASE;
        else if (code >= CODE_TMR0_FIRST && code <= CODE_TMR0_LAST)
            r.idx = elr_idx_t'(code - CODE_TMR0_FIRST) + IDX_TMR0_BASE;
        else if (code >= CODE_TMR2_FIRST && code <= CODE_TMR2_LAST)
            r.idx = elr_idx_t'(code - CODE_TMR2_FIRST) + IDX_TMR2_BASE;
        else if (code >= CODE_SER5_FIRST && code <= CODE_SER5_LAST)
            r.idx = elr_idx_t'(code - CODE_SER5_FIRST) + IDX_SER5_BASE;
        else if (code >= CODE_TWI0_FIRST && code <= CODE_TWI0_LAST)
            r.idx = elr_idx_t'(code - CODE_TWI0_FIRST) + IDX_TWI0_BASE;
        else
        begin
            case (code)
                CODE_CMT1:         r.idx = IDX_CMT1;
                CODE_ADC_CMP_MET:  r.idx = IDX_ADC_CMP_MET;
                CODE_ADC_CMP_MISS: r.idx = IDX_ADC_CMP_MISS;
                CODE_ADC_END:      r.idx = IDX_ADC_END;
                CODE_CMP0:         r.idx = IDX_CMP0;
                CODE_CMP01:        r.idx = IDX_CMP01;
                CODE_VDET1:        r.idx = IDX_VDET1;
                CODE_XFER_END:     r.idx = IDX_XFER_END;
                CODE_PGRP1:        r.idx = IDX_PGRP1;
                CODE_PSGL0:        r.idx = IDX_PSGL0;
                CODE_PSGL1:        r.idx = IDX_PSGL1;
                CODE_SW_EVENT:     r.idx = IDX_SW_EVENT;
                CODE_DOC:          r.idx = IDX_DOC;
                default:           r.valid = 1'b0;
            endcase
        end
        return r;
    endfunction

endpackage

// *** core/elr_port_edge.sv ***
`timescale 1ns/1ns
module elr_port_edge
    import elr_pkg::*;
(
    input  wire logic               ref_clk_in,
    input  wire logic               reset_in,
    input  wire logic               stop_in,
    input  wire logic [PORTB_W-1:0] pins_in,
    input  wire logic               mode_in,
    input  wire logic [2:0]         bit_sel_in,
    input  wire logic [PORTB_W-1:0] group_mask_in,
    output logic                    single_edge_out,
    output logic                    group_edge_out
);

    logic [PORTB_W-1:0] pins_prev_reg;
    wire  [PORTB_W-1:0] rise_edges;

    ////////////////////////////////////////////////////////////////////////
    // Previous pin levels, frozen while stopped
    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
            pins_prev_reg <= {PORTB_W{PB_PREV_RESET}};
        else if (!stop_in)
            pins_prev_reg <= pins_in;
    end

    assign rise_edges      = pins_in & ~pins_prev_reg & {PORTB_W{~stop_in}};
    assign single_edge_out = (mode_in == PB_MODE_SINGLE) & rise_edges[bit_sel_in];
    assign group_edge_out  = (mode_in == PB_MODE_GROUP)
                           & (|(rise_edges & group_mask_in));

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);

    chk_single_pin_edge: assert property (
        (mode_in == PB_MODE_SINGLE && !stop_in && !$past(stop_in) && !$past(reset_in)
         && pins_in[bit_sel_in] && !$past(pins_in[bit_sel_in])) |-> single_edge_out)
        else $error("single port edge missed");

    chk_single_only_sel: assert property (
        single_edge_out |-> (mode_in == PB_MODE_SINGLE && !group_edge_out))
        else $error("single port event outside single mode");

    chk_group_edge: assert property (
        (mode_in == PB_MODE_GROUP && !stop_in && !$past(stop_in) && !$past(reset_in)
         && |(pins_in & ~$past(pins_in) & group_mask_in)) |-> group_edge_out)
        else $error("group port edge missed");

    chk_group_masked: assert property (
        group_edge_out |-> (mode_in == PB_MODE_GROUP && |(pins_in & group_mask_in)))
        else $error("group event without masked pin high");

endmodule

// *** tb/elr_periph_model.sv ***
`timescale 1ns/1ns
module elr_periph_model
    import elr_pkg::*;
(
    input  wire logic [NUM_SRC-1:0] req_in,
    input  wire logic               sw_req_in,
    input  wire logic [PORTB_W-1:0] pin_lvl_in,
    output logic      [NUM_SRC-1:0] periph_event_out,
    output logic                    sw_event_out,
    output logic      [PORTB_W-1:0] portb_pins_out
);
    // Peripherals raise one pulse per request cycle, pins follow their levels
    assign periph_event_out = req_in;
    assign sw_event_out     = sw_req_in;
    assign portb_pins_out   = pin_lvl_in;
endmodule

// *** tb/elr_event_router_tb.sv ***
`timescale 1ns/1ns
module elr_event_router_tb
    import elr_pkg::*;
;
    logic                      ref_clk_in = 1'b0;
    logic                      reset_in;
    logic                      stop_in;
    logic [NUM_DEST-1:0]       sel_wr_in;
    logic [7:0]                sel_data_in;
    logic [NUM_SRC-1:0]        periph_event_in;
    logic [NUM_SRC-1:0]        req;
    logic                      sw_event_in;
    logic                      sw_req;
    logic [NUM_TIMER-1:0][1:0] timer_op_in;
    logic [PORTB_W-1:0]        portb_pins_in;
    logic [PORTB_W-1:0]        pin_lvl;
    logic                      portb_mode_in;
    logic [2:0]                portb_bit_sel_in;
    logic [PORTB_W-1:0]        portb_group_mask_in;
    logic [NUM_DEST-1:0]       dest_event_out;
    elr_tcmd_s [NUM_TIMER-1:0] timer_cmd_out;
    logic                      stopped_out;
    int                        n_fail = 0;
    int                        n_compared = 0;
    logic [7:0]                seg_code [11] = '{8'h08, 8'h1f, 8'h22, 8'h28, 8'h34, 8'h3a,
                                                 8'h4e, 8'h58, 8'h61, 8'h66, 8'h6a};
    int                        seg_idx [11] = '{0, 19, 20, 23, 26, 28, 32, 36, 40, 43, 45};
    int                        seg_n [11] = '{19, 1, 3, 3, 2, 4, 4, 4, 1, 1, 1};

    always #10 ref_clk_in = ~ref_clk_in;

    elr_periph_model elr_periph_model_inst (
        .req_in           (req),
        .sw_req_in        (sw_req),
        .pin_lvl_in       (pin_lvl),
        .periph_event_out (periph_event_in),
        .sw_event_out     (sw_event_in),
        .portb_pins_out   (portb_pins_in)
    );

    elr_event_router elr_event_router_inst (
        .ref_clk_in          (ref_clk_in),
        .reset_in            (reset_in),
        .stop_in             (stop_in),
        .sel_wr_in           (sel_wr_in),
        .sel_data_in         (sel_data_in),
        .periph_event_in     (periph_event_in),
        .sw_event_in         (sw_event_in),
        .timer_op_in         (timer_op_in),
        .portb_pins_in       (portb_pins_in),
        .portb_mode_in       (portb_mode_in),
        .portb_bit_sel_in    (portb_bit_sel_in),
        .portb_group_mask_in (portb_group_mask_in),
        .dest_event_out      (dest_event_out),
        .timer_cmd_out       (timer_cmd_out),
        .stopped_out         (stopped_out)
    );

    ////////////////////////////////////////////////////////////////////////
    // Shared helpers; all start and end at a falling edge
    task automatic tally_and_finish;
        $display("Counts: compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wr_sel(input logic [7:0] dmask, input logic [7:0] code);
        sel_wr_in   = dmask;
        sel_data_in = code;
        @(negedge ref_clk_in);
        sel_wr_in = '0;
    endtask

    task automatic fire(input logic [NUM_SRC-1:0] m, input logic sw);
        req    = m;
        sw_req = sw;
        @(negedge ref_clk_in);
        req    = '0;
        sw_req = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic reset_state;
        chk8(dest_event_out, 8'h00, "dest after reset");
        chk8(timer_cmd_out, 8'h00, "timer cmd after reset");
        chk8({7'h0, stopped_out}, 8'h00, "stopped after reset");
        fire('1, 1'b1);
        chk8(dest_event_out, 8'h00, "unlinked dest fired");
    endtask

    task automatic code_table;
        int         idx;
        logic [2:0] d;
        for (int s = 0; s < 11; s++)
            for (int k = 0; k < seg_n[s]; k++)
            begin
                idx = seg_idx[s] + k;
                d   = 3'(idx);
                wr_sel(8'h01 << d, seg_code[s] + 8'(k));
                fire(48'h1 << idx, 1'b0);
                chk8(dest_event_out, 8'h01 << d, "listed code");
                @(negedge ref_clk_in);
                fire(~(48'h1 << idx), 1'b1);
                chk8(dest_event_out & (8'h01 << d), 8'h00, "foreign source");
            end
    endtask

    task automatic timer_action;
        wr_sel(8'h03, 8'h58);
        for (int op = 0; op < 4; op++)
        begin
            timer_op_in[0] = 2'(op);
            timer_op_in[1] = 2'(3 - op);
            @(negedge ref_clk_in);
            fire(48'h1 << 36, 1'b0);
            // Dest 4 still holds 58h from the code table
            chk8(dest_event_out, 8'h13, "timer dests");
            chk8({4'h0, timer_cmd_out[0]}, 8'h08 >> op, "timer 0 action");
            chk8({4'h0, timer_cmd_out[1]}, 8'h08 >> (3 - op), "timer 1 action");
            @(negedge ref_clk_in);
            chk8(timer_cmd_out, 8'h00, "timer cmd idle");
        end
    endtask

    task automatic port_single;
        portb_mode_in    = PB_MODE_SINGLE;
        portb_bit_sel_in = 3'h5;
        wr_sel(8'h04, 8'h65);
        pin_lvl = 8'h08;
        @(negedge ref_clk_in);
        chk8(dest_event_out, 8'h00, "unselected pin");
        pin_lvl = 8'h28;
        @(negedge ref_clk_in);
        chk8(dest_event_out, 8'h04, "selected pin edge");
    endtask

    task automatic port_group;
        portb_mode_in       = PB_MODE_GROUP;
        portb_group_mask_in = 8'h18;
        pin_lvl             = 8'h00;
        wr_sel(8'h04, 8'h63);
        pin_lvl = 8'h01;
        @(negedge ref_clk_in);
        chk8(dest_event_out, 8'h00, "unmasked pin");
        pin_lvl = 8'h11;
        @(negedge ref_clk_in);
        chk8(dest_event_out, 8'h04, "masked pin edge");
        pin_lvl = 8'h00;
        @(negedge ref_clk_in);
    endtask

    task automatic module_stop;
        stop_in = 1'b1;
        @(negedge ref_clk_in);
        chk8({7'h0, stopped_out}, 8'h01, "stopped flag");
        wr_sel(8'h10, 8'h69);
        pin_lvl = 8'h10;
        fire('0, 1'b1);
        chk8(dest_event_out, 8'h00, "routed in stop");
        stop_in = 1'b0;
        @(negedge ref_clk_in);
        chk8(dest_event_out, 8'h04, "frozen edge history");
        chk8({7'h0, stopped_out}, 8'h00, "running flag");
        fire('0, 1'b1);
        chk8(dest_event_out, 8'h10, "write during stop");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence and watchdog
    initial
    begin
        reset_in            = 1'b1;
        stop_in             = 1'b0;
        sel_wr_in           = '0;
        sel_data_in         = 8'h00;
        req                 = '0;
        sw_req              = 1'b0;
        timer_op_in         = '0;
        pin_lvl             = 8'h00;
        portb_mode_in       = PB_MODE_SINGLE;
        portb_bit_sel_in    = 3'h0;
        portb_group_mask_in = 8'h00;
        repeat (12) @(negedge ref_clk_in);
        reset_in = 1'b0;
        @(negedge ref_clk_in);
        reset_state();
        code_table();
        timer_action();
        port_single();
        port_group();
        module_stop();
        tally_and_finish();
    end

    initial
    begin
        #400000;
        n_fail++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        tally_and_finish();
    end
endmodule
